// ---- rtl/ffm_top.v ----
`timescale 1ns/10ps
`include "ffm_consts.vh"

// Operation
// - Fail-safe entry reloads whole nonvolatile image
// - After reload, compute CRC into computed register
// - CRC mismatch: outputs off, pin low, flags
// - Undervoltage: reset state, power-on flag, pin low
// - Low supply sets flags, auto-clears, no pin
// - Ref, overtemp, CRC fault in fail-safe: all off, flagged
// - Fault removal recovers automatically, flags clear
// - Diag in fail-safe qualified by pulse and enables; 10ms retry
// - Reset state clears registers, ignores host access
// - Leave reset only when both supplies good
// - Any supply drop returns to reset at once
// - All-fail select: pin low in fail-safe turns everything off
module ffm_top #(
  parameter NCH = 12,
  parameter RETRY_CYCLES = `FFM_RETRY_CYCLES,
  parameter INIT_CYCLES = `FFM_INIT_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire supply_uv,
  input wire ldo_uv,
  input wire low_supply,
  input wire ref_fault,
  input wire overtemp,
  input wire [NCH-1:0] open_det,
  input wire [NCH-1:0] short_det,
  input wire [NCH-1:0] pulse_long,
  input wire fault_pin_in,
  output reg fault_pin_out,
  output reg fault_pin_oe,
  output reg [NCH-1:0] channel_on,
  output reg [NCH-1:0] diag_active,
  output reg irq
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_POR = 3'd0;
  localparam ST_INIT = 3'd1;
  localparam ST_NORMAL = 3'd2;
  localparam ST_LOAD = 3'd3;
  localparam ST_CRC = 3'd4;
  localparam ST_FS = 3'd5;
  localparam LW = 5;

  reg [2:0] state;
  reg [LW-1:0] load_idx;
  reg [31:0] init_cnt;
  reg [31:0] retry_cnt;
  reg retry_seen;
  reg [7:0] computed_crc_value;
  reg [7:0] stored_crc_value;
  reg [NCH-1:0] channel_enable;
  reg [NCH-1:0] channel_diag_enable;
  reg all_fail_select;
  reg force_fs;
  reg [NCH-1:0] open_channel_flag;
  reg [NCH-1:0] short_channel_flag;
  reg power_on_flag;
  reg low_supply_flag;
  reg ref_flag;
  reg overtemp_flag;
  reg crc_mismatch_flag;
  reg [`FFM_NUM_FLAGS-1:0] irq_stat;
  reg [`FFM_NUM_FLAGS-1:0] irq_mask;
  reg nvm_we;
  reg [3:0] nvm_waddr;
  reg [31:0] nvm_wdata;
  reg [3:0] nvm_raddr;
  wire [31:0] nvm_rdata;
  reg [7:0] crc_acc;
  reg [31:0] next_prdata;
  integer i;

  wire uv = supply_uv | ldo_uv;
  wire in_fs = (state == ST_FS);
  wire apb_acc = psel & penable & ~pready;
  wire host_ok = (state != ST_POR);
  wire wr = apb_acc & pwrite & host_ok;
  wire rd = apb_acc & ~pwrite & host_ok;
  wire retry_tick = (retry_cnt == RETRY_CYCLES - 1);
  wire [NCH-1:0] diag_ok = channel_enable & channel_diag_enable
    & pulse_long;
  wire [NCH-1:0] open_hit = open_det & diag_ok & {NCH{~low_supply}};
  wire [NCH-1:0] short_hit = short_det & diag_ok;
  wire all_off = ref_flag | overtemp_flag | crc_mismatch_flag;
  wire ch_fault = |(open_channel_flag | short_channel_flag);
  wire any_flag = power_on_flag | low_supply_flag | all_off | ch_fault;
  wire pin_drive = (state == ST_POR) | power_on_flag
    | (in_fs & (all_off | ch_fault));
  wire [`FFM_NUM_FLAGS-1:0] flag_vec = {any_flag, |short_channel_flag,
    |open_channel_flag, crc_mismatch_flag, overtemp_flag, ref_flag,
    low_supply_flag, power_on_flag};

  ffm_nvm #(.AW(4), .DW(32)) u_nvm (
    .pclk(pclk),
    .we(nvm_we),
    .waddr(nvm_waddr),
    .wdata(nvm_wdata),
    .raddr(nvm_raddr),
    .rdata(nvm_rdata)
  );

  // ----------------------------------------------------------------
  // Mode sequencing and nonvolatile reload
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_POR;
      load_idx <= {LW{1'b0}};
      init_cnt <= 32'h0;
      nvm_raddr <= 4'h0;
      crc_acc <= 8'h0;
      computed_crc_value <= 8'h0;
      stored_crc_value <= 8'h0;
      channel_enable <= {NCH{1'b0}};
      channel_diag_enable <= {NCH{1'b0}};
      all_fail_select <= 1'b0;
    end else if (uv) begin
      state <= ST_POR;
      load_idx <= {LW{1'b0}};
      init_cnt <= 32'h0;
      channel_enable <= {NCH{1'b0}};
      channel_diag_enable <= {NCH{1'b0}};
      all_fail_select <= 1'b0;
      computed_crc_value <= 8'h0;
    end else begin
      case (state)
        ST_POR: begin
          state <= ST_INIT;
        end
        ST_INIT: begin
          init_cnt <= init_cnt + 32'h1;
          if (init_cnt == INIT_CYCLES - 1) begin
            state <= ST_NORMAL;
          end
          if (wr && paddr == `FFM_ADDR_CTRL
              && pwdata[`FFM_CTRL_POR_CLR]) begin
            state <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (wr && paddr == `FFM_ADDR_CH_EN) begin
            channel_enable <= pwdata[NCH-1:0];
          end
          if (wr && paddr == `FFM_ADDR_CH_DIAG) begin
            channel_diag_enable <= pwdata[NCH-1:0];
          end
          if (wr && paddr == `FFM_ADDR_CTRL) begin
            all_fail_select <= pwdata[`FFM_CTRL_ALL_FAIL];
          end
          if (force_fs) begin
            state <= ST_LOAD;
            load_idx <= {LW{1'b0}};
            nvm_raddr <= 4'h0;
            crc_acc <= `FFM_CRC_INIT;
          end
        end
        ST_LOAD: begin
          // Read data trails the address by one cycle
          nvm_raddr <= nvm_raddr + 4'h1;
          load_idx <= load_idx + {{(LW-1){1'b0}}, 1'b1};
          if (load_idx != {LW{1'b0}}) begin
            case (load_idx - {{(LW-1){1'b0}}, 1'b1})
              5'd0: channel_enable <= nvm_rdata[NCH-1:0];
              5'd1: channel_diag_enable <= nvm_rdata[NCH-1:0];
              5'd2: all_fail_select <= nvm_rdata[0];
              5'd15: stored_crc_value <= nvm_rdata[7:0];
              default: ;
            endcase
            if (load_idx != 5'd16) begin
              crc_acc <= crc_acc ^ nvm_rdata[7:0] ^ nvm_rdata[15:8]
                ^ nvm_rdata[23:16] ^ nvm_rdata[31:24];
            end
          end
          if (load_idx == 5'd16) begin
            state <= ST_CRC;
          end
        end
        ST_CRC: begin
          computed_crc_value <= crc_acc;
          state <= ST_FS;
        end
        ST_FS: begin
          if (wr && paddr == `FFM_ADDR_CTRL
              && pwdata[`FFM_CTRL_CLR_FS]) begin
            state <= ST_NORMAL;
          end
        end
        default: state <= ST_POR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fault flags
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on_flag <= 1'b1;
      low_supply_flag <= 1'b0;
      ref_flag <= 1'b0;
      overtemp_flag <= 1'b0;
      crc_mismatch_flag <= 1'b0;
      force_fs <= 1'b0;
      open_channel_flag <= {NCH{1'b0}};
      short_channel_flag <= {NCH{1'b0}};
      retry_cnt <= 32'h0;
      retry_seen <= 1'b0;
    end else begin
      if (uv) begin
        power_on_flag <= 1'b1;
      end else if (wr && paddr == `FFM_ADDR_CTRL
                   && pwdata[`FFM_CTRL_POR_CLR]) begin
        power_on_flag <= 1'b0;
      end
      low_supply_flag <= low_supply;
      force_fs <= (state == ST_NORMAL) & wr & (paddr == `FFM_ADDR_CTRL)
        & pwdata[`FFM_CTRL_FORCE_FS];
      retry_cnt <= retry_tick ? 32'h0 : retry_cnt + 32'h1;
      // Retry pulse is on the pins one cycle after the tick
      retry_seen <= retry_tick;
      if (in_fs) begin
        ref_flag <= ref_fault;
        overtemp_flag <= overtemp;
        crc_mismatch_flag <= computed_crc_value != stored_crc_value;
        for (i = 0; i < NCH; i = i + 1) begin
          // Flags hold until the retry pulse has sensed the channel good,
          // so the fault pin is not let go while the fault persists
          if (open_hit[i]) begin
            open_channel_flag[i] <= 1'b1;
          end else if (retry_seen) begin
            open_channel_flag[i] <= 1'b0;
          end
          if (short_hit[i]) begin
            short_channel_flag[i] <= 1'b1;
          end else if (retry_seen) begin
            short_channel_flag[i] <= 1'b0;
          end
        end
      end else begin
        ref_flag <= 1'b0;
        overtemp_flag <= 1'b0;
        crc_mismatch_flag <= 1'b0;
        open_channel_flag <= {NCH{1'b0}};
        short_channel_flag <= {NCH{1'b0}};
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_on <= {NCH{1'b0}};
      diag_active <= {NCH{1'b0}};
      fault_pin_out <= 1'b0;
      fault_pin_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      fault_pin_oe <= pin_drive;
      fault_pin_out <= 1'b0;
      irq <= |(irq_stat & irq_mask);
      if (state == ST_POR || uv || (in_fs && all_off)) begin
        channel_on <= {NCH{1'b0}};
        diag_active <= {NCH{1'b0}};
      end else if (in_fs && all_fail_select && !fault_pin_in) begin
        channel_on <= {NCH{1'b0}};
        diag_active <= {NCH{1'b0}};
      end else if (in_fs) begin
        // Failed channel stays off except during a retry pulse
        channel_on <= channel_enable & ~((open_channel_flag
          | short_channel_flag) & {NCH{~retry_tick}});
        diag_active <= diag_ok;
      end else begin
        channel_on <= channel_enable;
        diag_active <= channel_enable & channel_diag_enable;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave and interrupts
  // ----------------------------------------------------------------
  always @* begin
    next_prdata = 32'h0;
    case (paddr)
      `FFM_ADDR_STATUS: next_prdata = {29'h0, state};
      `FFM_ADDR_FLAGS: next_prdata = {24'h0, flag_vec};
      `FFM_ADDR_IRQ_STAT: next_prdata = {24'h0, irq_stat};
      `FFM_ADDR_IRQ_MASK: next_prdata = {24'h0, irq_mask};
      `FFM_ADDR_CRC: next_prdata = {16'h0, stored_crc_value,
        computed_crc_value};
      `FFM_ADDR_CH_EN: next_prdata = {{(32-NCH){1'b0}}, channel_enable};
      `FFM_ADDR_CH_DIAG: next_prdata = {{(32-NCH){1'b0}},
        channel_diag_enable};
      `FFM_ADDR_OPEN: next_prdata = {{(32-NCH){1'b0}}, open_channel_flag};
      `FFM_ADDR_SHORT: next_prdata = {{(32-NCH){1'b0}},
        short_channel_flag};
      `FFM_ADDR_CTRL: next_prdata = {29'h0, all_fail_select, 2'b00};
      default: next_prdata = 32'h0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      irq_stat <= {`FFM_NUM_FLAGS{1'b0}};
      irq_mask <= {`FFM_NUM_FLAGS{1'b0}};
      nvm_we <= 1'b0;
      nvm_waddr <= 4'h0;
      nvm_wdata <= 32'h0;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~host_ok;
      prdata <= rd ? next_prdata : 32'h0;
      nvm_we <= wr & (paddr == `FFM_ADDR_NVM_DATA);
      nvm_wdata <= pwdata;
      if (wr && paddr == `FFM_ADDR_NVM_ADDR) begin
        nvm_waddr <= pwdata[3:0];
      end
      if (wr && paddr == `FFM_ADDR_IRQ_MASK) begin
        irq_mask <= pwdata[`FFM_NUM_FLAGS-1:0];
      end
      if (wr && paddr == `FFM_ADDR_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~pwdata[`FFM_NUM_FLAGS-1:0])
          | flag_vec;
      end else begin
        irq_stat <= irq_stat | flag_vec;
      end
    end
  end
endmodule // ffm_top

// ---- rtl/ffm_consts.vh ----
`ifndef FFM_CONSTS_VH
`define FFM_CONSTS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FFM_ADDR_CTRL 12'h000
`define FFM_ADDR_STATUS 12'h004
`define FFM_ADDR_FLAGS 12'h008
`define FFM_ADDR_IRQ_STAT 12'h00c
`define FFM_ADDR_IRQ_MASK 12'h010
`define FFM_ADDR_CRC 12'h014
`define FFM_ADDR_CH_EN 12'h018
`define FFM_ADDR_CH_DIAG 12'h01c
`define FFM_ADDR_OPEN 12'h020
`define FFM_ADDR_SHORT 12'h024
`define FFM_ADDR_NVM_ADDR 12'h028
`define FFM_ADDR_NVM_DATA 12'h02c
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define FFM_CTRL_POR_CLR 0
`define FFM_CTRL_FORCE_FS 1
`define FFM_CTRL_ALL_FAIL 2
`define FFM_CTRL_CLR_FS 3
// ----------------------------------------------------------------
// Flag fields
// ----------------------------------------------------------------
`define FFM_FLAG_POR 0
`define FFM_FLAG_LOWSUP 1
`define FFM_FLAG_REF 2
`define FFM_FLAG_OT 3
`define FFM_FLAG_CRC 4
`define FFM_FLAG_OPEN 5
`define FFM_FLAG_SHORT 6
`define FFM_FLAG_ANY 7
`define FFM_NUM_FLAGS 8
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FFM_CLK_MHZ 250
`define FFM_RETRY_MS 10
`define FFM_RETRY_CYCLES (`FFM_RETRY_MS * 1000 * `FFM_CLK_MHZ)
`define FFM_INIT_CYCLES 1000
`define FFM_NVM_WORDS 16
`define FFM_CRC_INIT 8'hff
`endif

// ---- rtl/ffm_nvm.v ----
`timescale 1ns/10ps
// Nonvolatile image model: synchronous write, registered read
module ffm_nvm #(
  parameter AW = 4,
  parameter DW = 32
) (
  input wire pclk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // ffm_nvm

// ---- dv/ffm_chk.sv ----
`timescale 1ns/10ps
module ffm_chk #(
  parameter NCH = 12
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire supply_uv,
  input wire ldo_uv,
  input wire overtemp,
  input wire fault_pin_out,
  input wire fault_pin_oe,
  input wire [NCH-1:0] channel_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire uv = supply_uv | ldo_uv;
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_por;
    uv [*3];
  endsequence
  AST_PREADY_LAT: assert property (s_access |=> pready)
    else $error("pready late");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_ERR_PAIR: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  AST_OPEN_DRAIN: assert property (fault_pin_oe |-> !fault_pin_out)
    else $error("fault pin driven high");
  AST_UV_PIN: assert property (uv |-> ##[1:2] fault_pin_oe)
    else $error("fault pin not sunk on undervoltage");
  AST_UV_OFF: assert property (uv |-> ##2 channel_on == '0)
    else $error("channels on in undervoltage");
  AST_POR_REFUSE: assert property (
    s_por ##1 (pready && uv) |-> pslverr && prdata == 32'h0)
    else $error("access served in reset state");
  AST_OT_OFF: assert property (overtemp [*2] |-> ##1 channel_on == '0)
    else $error("channels on in overtemperature");
endmodule // ffm_chk

bind ffm_top ffm_chk #(.NCH(NCH)) ffm_chk_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .supply_uv(supply_uv),
  .ldo_uv(ldo_uv), .overtemp(overtemp), .fault_pin_out(fault_pin_out),
  .fault_pin_oe(fault_pin_oe), .channel_on(channel_on));

// ---- dv/ffm_peer.sv ----
`timescale 1ns/10ps
module ffm_peer #(
  parameter NCH = 12
) (
  input wire logic [NCH-1:0] channel_on,
  input wire logic [NCH-1:0] open_fail,
  input wire logic [NCH-1:0] short_fail,
  input wire logic fault_pin_oe,
  input wire logic peer_pull,
  output logic [NCH-1:0] open_det,
  output logic [NCH-1:0] short_det,
  output logic [NCH-1:0] pulse_long,
  output logic fault_pin_in
);
  // A failed LED is only sensed while its stage drives current
  assign open_det = channel_on & open_fail;
  assign short_det = channel_on & short_fail;
  // Long on-pulses: every driven channel qualifies for diagnosis
  assign pulse_long = channel_on;
  // Pulled-up fault bus, low if this device or a peer sinks it
  assign fault_pin_in = ~(fault_pin_oe | peer_pull);
endmodule // ffm_peer

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    failures++; $display("Error at %0t got %h exp %h", $time, g, e); end end
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, em, mm;
  logic pready, pslverr, supply_uv = '0, ldo_uv = '0, low_supply = '0;
  logic ref_fault = '0, overtemp = '0, peer_pull = '0, irq;
  logic fault_pin_in, fault_pin_out, fault_pin_oe;
  logic [11:0] open_det, short_det, pulse_long, channel_on, diag_active;
  logic [11:0] open_fail = '0, short_fail = '0;
  logic [31:0] w [16], expq [$], mq [$];
  logic eq [$], ee;
  logic [7:0] crc;
  int failures = 0, samples_checked = 0, n = 0;
  always #2 pclk = ~pclk;
  ffm_top #(.RETRY_CYCLES(50), .INIT_CYCLES(20)) ffm_top_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .supply_uv, .ldo_uv, .low_supply, .ref_fault, .overtemp,
    .open_det, .short_det, .pulse_long, .fault_pin_in, .fault_pin_out,
    .fault_pin_oe, .channel_on, .diag_active, .irq);
  ffm_peer ffm_peer_inst (.channel_on, .open_fail, .short_fail,
    .fault_pin_oe, .peer_pull, .open_det, .short_det, .pulse_long,
    .fault_pin_in);
  // ----------------------------------------------------------------
  // Bus master and read monitor
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] m = '1, input logic e = 1'b0);
    @(posedge pclk);
    if (!wr) begin
      expq.push_back(d & m);
      mq.push_back(m);
      eq.push_back(e);
    end
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      em = expq.pop_front();
      mm = mq.pop_front();
      ee = eq.pop_front();
      `CHK(prdata & mm, em)
      `CHK(pslverr, ee)
    end
  end
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic done;
    n++;
    $display("test %0d done", n);
  endtask
  task automatic prog(input logic af, input logic [7:0] bad);
    w[2] = {31'h0, af};
    crc = 8'hff;
    for (int i = 0; i < 15; i++)
      crc ^= w[i][7:0] ^ w[i][15:8] ^ w[i][23:16] ^ w[i][31:24];
    w[15] = {24'h0, crc ^ bad};
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 12'h028, i);
      apb(1'b1, 12'h02c, w[i]);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    wt(20000);
    failures++;
    stop_test;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(57));
    foreach (w[i]) w[i] = $urandom;
    w[0] = {20'h0, w[0][11:1], 1'b1};
    w[1] = 32'h0000_0fff;
    wt(2);
    presetn <= 1'b1;
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h008, 32'h0, 32'h1);
    prog(1'b0, 8'h00);
    apb(1'b1, 12'h000, 32'h2);
    wt(30);
    apb(1'b0, 12'h004, 32'h5, 32'h7);
    apb(1'b0, 12'h014, {16'h0, crc, crc}, 32'hffff);
    apb(1'b0, 12'h018, w[0], 32'hfff);
    apb(1'b0, 12'h01c, w[1], 32'hfff);
    `CHK(channel_on, w[0][11:0])
    `CHK(fault_pin_oe, 1'b0)
    done;
    for (int k = 0; k < 2; k++) begin
      if (k == 0) open_fail <= 12'h001;
      else short_fail <= 12'h001;
      wt(4);
      `CHK(channel_on, w[0][11:0] & 12'hffe)
      `CHK(fault_pin_oe, 1'b1)
      wt(20);
      `CHK(channel_on, w[0][11:0] & 12'hffe)
      `CHK(fault_pin_oe, 1'b1)
      open_fail <= '0;
      short_fail <= '0;
      wt(120);
      `CHK(channel_on, w[0][11:0])
      `CHK(fault_pin_oe, 1'b0)
    end
    done;
    for (int k = 0; k < 2; k++) begin
      if (k == 0) ref_fault <= 1'b1;
      else overtemp <= 1'b1;
      wt(4);
      `CHK(channel_on, 12'h000)
      apb(1'b0, 12'h008, 32'h84 + 4 * k, 32'h8c);
      ref_fault <= 1'b0;
      overtemp <= 1'b0;
      wt(4);
      `CHK(channel_on, w[0][11:0])
      apb(1'b0, 12'h008, 32'h0, 32'hfc);
    end
    done;
    apb(1'b1, 12'h010, 32'h2);
    low_supply <= 1'b1;
    wt(4);
    `CHK(fault_pin_oe, 1'b0)
    `CHK(irq, 1'b1)
    apb(1'b0, 12'h008, 32'h82, 32'h82);
    apb(1'b1, 12'h00c, 32'h2);
    wt(1);
    `CHK(irq, 1'b1)
    apb(1'b1, 12'h010, 32'h0);
    wt(2);
    `CHK(irq, 1'b0)
    low_supply <= 1'b0;
    apb(1'b1, 12'h010, 32'h2);
    wt(2);
    `CHK(irq, 1'b1)
    apb(1'b0, 12'h008, 32'h0, 32'h82);
    apb(1'b1, 12'h00c, 32'h2);
    wt(2);
    `CHK(irq, 1'b0)
    done;
    for (int k = 0; k < 2; k++) begin
      if (k == 0) supply_uv <= 1'b1;
      else ldo_uv <= 1'b1;
      wt(4);
      `CHK(channel_on, 12'h000)
      `CHK(fault_pin_oe, 1'b1)
      apb(1'b0, 12'h004, 32'h0, '1, 1'b1);
      supply_uv <= 1'b0;
      ldo_uv <= 1'b0;
      wt(2);
      apb(1'b0, 12'h004, 32'h1, 32'h7);
      apb(1'b0, 12'h008, 32'h81, 32'h81);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h008, 32'h0, 32'h1);
    end
    done;
    prog(1'b1, 8'h00);
    apb(1'b1, 12'h000, 32'h2);
    wt(30);
    peer_pull <= 1'b1;
    wt(4);
    `CHK(channel_on, 12'h000)
    `CHK(diag_active, 12'h000)
    peer_pull <= 1'b0;
    wt(4);
    `CHK(channel_on, w[0][11:0])
    `CHK(diag_active, w[0][11:0])
    apb(1'b1, 12'h000, 32'h8);
    prog(1'b0, 8'h01);
    apb(1'b1, 12'h000, 32'h2);
    wt(30);
    `CHK(channel_on, 12'h000)
    `CHK(fault_pin_oe, 1'b1)
    apb(1'b0, 12'h008, 32'h90, 32'h90);
    apb(1'b0, 12'h014, {16'h0, crc ^ 8'h01, crc}, 32'hffff);
    done;
    stop_test;
  end
endmodule // tb_top
